// ==== dv/etc_pulse_src.sv ====
// Count pin and modulator tick source
`timescale 1ns/1ns
`default_nettype none
module etc_pulse_src (
    input wire logic clk,
    input wire logic reset,
    output logic count_input_pin,
    output logic mod_period_tick
);
    logic [1:0] ph_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ph_r <= 2'h0;
        end else begin
            ph_r <= ph_r + 2'h1;
        end
    end
    // Level held two clocks, so sampling loses no edge
    assign count_input_pin = ph_r[1];
    assign mod_period_tick = ph_r == 2'h3;
endmodule // etc_pulse_src
`default_nettype wire

// ==== dv/etc_timer_asserts.sv ====
// Port checker for the timer/counter
`timescale 1ns/1ns
`default_nettype none
module etc_timer_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire etc_pkg::etc_bus_req_t bus_req,
    input wire logic [7:0] rdata,
    input wire logic led_drive_pin,
    input wire logic wrap_flag,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic rq = bus_req.rd;
    wire logic wq = bus_req.wr;
    wire logic [2:0] ad = bus_req.addr;
    sequence s_wrc;
        wq && ad == 3'h4 ##1 !wq ##1 rq && ad == 3'h4;
    endsequence
    property p_ctl;
        s_wrc |=> rdata == ($past(bus_req.wdata, 3) & 8'h1F);
    endproperty
    property p_rdz; !$past(rq) |-> rdata == 8'h00; endproperty
    property p_unm;
        $past(rq && (ad == 3'h3 || ad > 3'h4)) |-> rdata == 8'h00;
    endproperty
    property p_flg; $past(rq && ad == 3'h1) |-> rdata[7:1] == 7'h00; endproperty
    property p_ien; $past(rq && ad == 3'h2) |-> rdata[7:1] == 7'h00; endproperty
    property p_irq; irq |-> wrap_flag || $past(wrap_flag); endproperty
    property p_stk;
        wrap_flag && !(wq && ad == 3'h1 && bus_req.wdata[0]) |=> wrap_flag;
    endproperty
    // Pin moves only on a wrap or a forced wrap
    property p_led;
        $changed(led_drive_pin) |->
            wrap_flag || $past(wq && ad == 3'h4 && bus_req.wdata[7]);
    endproperty
    a_ctl: assert property (p_ctl) else $error("ctrl readback");
    a_rdz: assert property (p_rdz) else $error("rdata not idle");
    a_unm: assert property (p_unm) else $error("unmapped read");
    a_flg: assert property (p_flg) else $error("flag read");
    a_ien: assert property (p_ien) else $error("enable read");
    a_irq: assert property (p_irq) else $error("irq without flag");
    a_stk: assert property (p_stk) else $error("flag dropped");
    a_led: assert property (p_led) else $error("led moved");
endmodule // etc_timer_asserts
bind etc_timer etc_timer_asserts i_etc_timer_asserts (.*);
`default_nettype wire

// ==== dv/etc_timer_tb_top.sv ====
// Self-checking bench for the timer/counter
`timescale 1ns/1ns
`default_nettype none
module etc_timer_tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic mod_period_tick, count_input_pin, led_drive_pin, wrap_flag, irq;
    logic [7:0] rdata, v, w;
    etc_pkg::etc_bus_req_t bus_req = '0;
    int bad_count = 0, checks = 0, cyc = 0;
    int gap[8] = '{62, 62, 62, 254, 1022, 4094, 62, 62};
    logic [7:0] dif[8] = '{8'h00, 8'h40, 8'h10, 8'h04, 8'h04, 8'h04, 8'h10,
        8'h10};
    logic [7:0] frc[6] = '{8'h88, 8'h90, 8'h98, 8'h98, 8'h80, 8'h80};
    logic [5:0] fled = 6'h39;
    etc_timer i_etc_timer (
        .clk(clk),
        .reset(reset),
        .bus_req(bus_req),
        .rdata(rdata),
        .mod_period_tick(mod_period_tick),
        .count_input_pin(count_input_pin),
        .led_drive_pin(led_drive_pin),
        .wrap_flag(wrap_flag),
        .irq(irq)
    );
    etc_pulse_src i_etc_pulse_src (
        .clk(clk),
        .reset(reset),
        .count_input_pin(count_input_pin),
        .mod_period_tick(mod_period_tick)
    );
    initial forever #4 clk = ~clk;
    task automatic acc(input logic [2:0] a, input logic [7:0] d,
        input logic r);
        bus_req <= '{a, d, !r, r};
        @(posedge clk);
        bus_req <= '0;
        #1 v = rdata;
        @(posedge clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d bad %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Longest path is the divide-by-1024 window
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 12000) begin
            bad_count++;
            give_verdict;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 8; a++) begin
            acc(3'(a), 8'h00, 1'b1);
            chk(v, 8'h00);
        end
        acc(3'h4, 8'hFF, 1'b0);
        acc(3'h4, 8'h00, 1'b1);
        chk(v, 8'h1F);
        chk({7'h00, led_drive_pin}, 8'h00);
        $display("regs done");
        for (int s = 0; s < 8; s++) begin
            acc(3'h4, 8'(s), 1'b0);
            acc(3'h0, 8'h00, 1'b1);
            w = v;
            repeat (gap[s]) @(posedge clk);
            acc(3'h0, 8'h00, 1'b1);
            chk(v - w, dif[s]);
        end
        $display("sources done");
        for (int e = 0; e < 2; e++) begin
            acc(3'h4, 8'h08, 1'b0);
            acc(3'h1, 8'h01, 1'b0);
            acc(3'h2, 8'(e), 1'b0);
            acc(3'h0, 8'hFE, 1'b0);
            acc(3'h4, 8'h09, 1'b0);
            acc(3'h0, 8'h00, 1'b1);
            chk(v, 8'hFF);
            chk({5'h00, wrap_flag, irq, led_drive_pin}, 8'(5 + e));
        end
        acc(3'h4, 8'h08, 1'b0);
        acc(3'h1, 8'h01, 1'b0);
        chk({6'h00, wrap_flag, irq}, 8'h00);
        for (int i = 0; i < 6; i++) begin
            acc(3'h4, frc[i], 1'b0);
            chk({6'h00, wrap_flag, led_drive_pin}, {7'h00, fled[i]});
        end
        $display("wrap done");
        give_verdict;
    end
endmodule // etc_timer_tb_top
`default_nettype wire

// ==== logic/etc_pkg.sv ====
// Constants and types for the eight-bit timer/counter
// Overview of operation
// - Eight-bit up-counter, software reads and writes it at any time.
// - After a counter write, counting resumes from written value next tick.
// - Select: 0 stop,1 clk,2 modulator,3 /64,4 /256,5 /1024,6 fall,7 rise.
// - Divided ticks come from a free-running ten-bit prescaler on clk.
// - Count pin is sampled on rising clk; only selected edge counts.
// - Pin edges count even while the pin is driven as an output.
// - Overflow sets sticky flag; interrupt request only when enable set.
// - Action field bits 4..3: none, toggle, drive low, drive high.
// - Writing one to force bit applies action, no flag, no interrupt.
// - Force written with new mode uses the previous mode.
// - Force bit reads zero; writing zero does nothing.
// - Control bits 6 and 5 ignore writes and read zero.
// - Modulator tick source keeps running regardless of latch bit.
package etc_pkg;
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFS_CTRL = 3'h4;
    localparam logic [2:0] OFS_COUNT = 3'h0;
    localparam logic [2:0] OFS_FLAG = 3'h1;
    localparam logic [2:0] OFS_IEN = 3'h2;
    localparam int FORCE_BIT = 7;
    localparam int MODE_LSB = 3;
    localparam int SEL_LSB = 0;
    localparam logic [7:0] CTRL_WMASK = 8'h1F;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [9:0] PRE_RST = 10'h000;
    localparam int TAP64 = 5;
    localparam int TAP256 = 7;
    localparam int TAP1024 = 9;

    typedef enum logic [2:0] {
        SRC_STOP, SRC_CLK, SRC_MOD, SRC_D64,
        SRC_D256, SRC_D1024, SRC_FALL, SRC_RISE
    } etc_src_t;

    typedef enum logic [1:0] {
        ACT_NONE, ACT_TOGGLE, ACT_LOW, ACT_HIGH
    } etc_act_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } etc_bus_req_t;
endpackage

// ==== logic/etc_timer.sv ====
// Eight-bit timer/counter with prescaler, pin sync and wrap action
`timescale 1ns/1ns
`default_nettype none
module etc_timer #(
    parameter int PRE_W = 10,
    parameter int SYNC_STAGES = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire etc_pkg::etc_bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic mod_period_tick,
    input wire logic count_input_pin,
    output logic led_drive_pin,
    output logic wrap_flag,
    output logic irq
);
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [PRE_W-1:0] pre_r, pre_nxt;
    logic [PRE_W-1:0] pre_q;
    logic [SYNC_STAGES-1:0] pin_sync_r, pin_sync_nxt;
    logic pin_prev_r, pin_prev_nxt;
    logic flag_r, flag_nxt;
    logic ien_r, ien_nxt;
    logic led_r, led_nxt;
    logic irq_r, irq_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic tick, wrap, force_act, pin_lvl;
    logic [1:0] act_mode;
    logic [PRE_W-1:0] pre_rise;

    // Slowest tap must exist in the prescaler
    if (PRE_W < etc_pkg::TAP1024 + 1) begin : g_pre_chk
        $error("prescaler narrower than slowest tap");
    end
    // Agreement needs two stages behind the first
    if (SYNC_STAGES < 3) begin : g_sync_chk
        $error("pin synchroniser needs three stages");
    end

    function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
        hit = (a == o);
    endfunction

    // Free running prescaler on clk; tap rising edges give divided ticks
    always_comb begin
        pre_nxt = pre_r + PRE_W'(1);
    end
    assign pre_q = pre_nxt;
    assign pre_rise = pre_q & ~pre_r;

    // Agreement of 2nd and 3rd stage; no clk of latency added
    assign pin_sync_nxt[0] = count_input_pin;
    for (genvar g = 1; g < SYNC_STAGES; g++) begin : g_sync
        assign pin_sync_nxt[g] = pin_sync_r[g-1];
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_sync_r <= '0;
        end else begin
            pin_sync_r <= pin_sync_nxt;
        end
    end

    always_comb begin
        pin_prev_nxt = pin_prev_r;
        if (pin_sync_r[SYNC_STAGES-2] == pin_sync_r[SYNC_STAGES-1]) begin
            pin_prev_nxt = pin_sync_r[SYNC_STAGES-1];
        end
    end
    assign pin_lvl = pin_prev_nxt;

    always_comb begin
        case (etc_pkg::etc_src_t'(ctrl_r[etc_pkg::SEL_LSB +: 3]))
            etc_pkg::SRC_STOP: tick = 1'b0;
            etc_pkg::SRC_CLK: tick = 1'b1;
            etc_pkg::SRC_MOD: tick = mod_period_tick;
            etc_pkg::SRC_D64: tick = pre_rise[etc_pkg::TAP64];
            etc_pkg::SRC_D256: tick = pre_rise[etc_pkg::TAP256];
            etc_pkg::SRC_D1024: tick = pre_rise[etc_pkg::TAP1024];
            etc_pkg::SRC_FALL: tick = pin_prev_r & ~pin_lvl;
            etc_pkg::SRC_RISE: tick = ~pin_prev_r & pin_lvl;
            default: tick = 1'b0;
        endcase
    end

    // Force uses the mode held before this write
    assign force_act = bus_req.wr && hit(bus_req.addr, etc_pkg::OFS_CTRL)
        && bus_req.wdata[etc_pkg::FORCE_BIT];
    assign act_mode = ctrl_r[etc_pkg::MODE_LSB +: 2];

    // Write wins over tick: counting resumes on the following tick
    always_comb begin
        cnt_nxt = cnt_r;
        wrap = 1'b0;
        if (bus_req.wr && hit(bus_req.addr, etc_pkg::OFS_COUNT)) begin
            cnt_nxt = bus_req.wdata;
        end else if (tick) begin
            cnt_nxt = cnt_r + 8'h01;
            wrap = (cnt_r == etc_pkg::COUNT_MAX);
        end
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (bus_req.wr && hit(bus_req.addr, etc_pkg::OFS_CTRL)) begin
            ctrl_nxt = bus_req.wdata & etc_pkg::CTRL_WMASK;
        end
    end

    always_comb begin
        led_nxt = led_r;
        if (wrap || force_act) begin
            case (etc_pkg::etc_act_t'(act_mode))
                etc_pkg::ACT_NONE: led_nxt = led_r;
                etc_pkg::ACT_TOGGLE: led_nxt = ~led_r;
                etc_pkg::ACT_LOW: led_nxt = 1'b0;
                etc_pkg::ACT_HIGH: led_nxt = 1'b1;
                default: led_nxt = led_r;
            endcase
        end
    end

    // Flag: write one clears; a wrap in the same cycle wins
    always_comb begin
        flag_nxt = flag_r;
        ien_nxt = ien_r;
        if (bus_req.wr && hit(bus_req.addr, etc_pkg::OFS_FLAG)
            && bus_req.wdata[0]) begin
            flag_nxt = 1'b0;
        end
        if (wrap) begin
            flag_nxt = 1'b1;
        end
        if (bus_req.wr && hit(bus_req.addr, etc_pkg::OFS_IEN)) begin
            ien_nxt = bus_req.wdata[0];
        end
        irq_nxt = flag_nxt & ien_nxt;
    end

    always_comb begin
        rdata_nxt = etc_pkg::BYTE_ZERO;
        if (bus_req.rd) begin
            case (bus_req.addr)
                etc_pkg::OFS_CTRL: rdata_nxt = ctrl_r;
                etc_pkg::OFS_COUNT: rdata_nxt = cnt_r;
                etc_pkg::OFS_FLAG: rdata_nxt = {7'h00, flag_r};
                etc_pkg::OFS_IEN: rdata_nxt = {7'h00, ien_r};
                default: rdata_nxt = etc_pkg::BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_r <= etc_pkg::CTRL_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r <= etc_pkg::COUNT_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Prescaler never stops, so taps keep phase across selects
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pre_r <= PRE_W'(etc_pkg::PRE_RST);
        end else begin
            pre_r <= pre_nxt;
        end
    end

    // Starts at the idle level of the synchroniser
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= pin_prev_nxt;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flag_r <= 1'b0;
            ien_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            ien_r <= ien_nxt;
            irq_r <= irq_nxt;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            led_r <= 1'b0;
        end else begin
            led_r <= led_nxt;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_r <= etc_pkg::BYTE_ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;
    assign led_drive_pin = led_r;
    assign wrap_flag = flag_r;
    assign irq = irq_r;
endmodule // etc_timer
`default_nettype wire
